// ---- rtl/line_err_pkg.sv ----
package line_err_pkg;

    // ------------------------------------------------------------------
    // Register offsets within one channel window
    // ------------------------------------------------------------------
    localparam logic [10:0] CH0_BASE        = 11'h7C0;
    localparam logic [10:0] CH_STRIDE       = 11'h040;
    localparam logic [5:0]  OFF_ABSENCE_CFG = 6'h0D;
    localparam logic [5:0]  OFF_FAULT_CTL   = 6'h0E;
    localparam logic [5:0]  OFF_ALARM_GEN   = 6'h0F;
    localparam logic [5:0]  OFF_COUNT_HIGH  = 6'h1A;
    localparam logic [5:0]  OFF_COUNT_LOW   = 6'h1B;
    localparam logic [5:0]  OFF_INT_STATUS  = 6'h1C;
    localparam logic [5:0]  OFF_INT_MASK    = 6'h1D;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] ABSENCE_CFG_RST = 8'h15;
    localparam logic [7:0] FAULT_CTL_RST   = 8'h00;
    localparam logic [3:0] ALARM_GEN_RST   = 4'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int EXZ_STD_BIT   = 7;
    localparam int VIOL_INS_BIT  = 6;
    localparam int SINGLE_ERROR_INSERT_BIT   = 5;
    localparam int SRC_LSB       = 2;
    localparam int LATCH_MD_BIT  = 1;
    localparam int LATCH_REQ_BIT = 0;
    localparam int RX_STD_BIT    = 7;
    localparam int RX_THR_LSB    = 4;
    localparam int TX_THR_LSB    = 2;
    localparam int TX_PER_LSB    = 0;
    localparam int RX_SYS_BIT    = 3;
    localparam int RX_LINE_BIT   = 2;
    localparam int TX_SYS_BIT    = 1;
    localparam int TX_LINE_BIT   = 0;

    // Interrupt status bit positions.
    localparam int INT_TX_ABS    = 0;
    localparam int INT_LINE_ABS  = 1;
    localparam int INT_LATCHED   = 2;
    localparam int INT_VIOL_DONE = 3;
    localparam int INT_ERR_DONE  = 4;
    localparam int INT_W         = 5;

    // ------------------------------------------------------------------
    // Counter sources and timing
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_OFF      = 3'b000,
        SRC_LV       = 3'b001,
        SRC_LZ       = 3'b010,
        SRC_LV_LZ    = 3'b011,
        SRC_SV       = 3'b100,
        SRC_SZ       = 3'b101,
        SRC_SV_SZ    = 3'b110,
        SRC_PATTERN  = 3'b111
    } count_src_t;

    localparam logic [6:0] TX_PULSES_16 = 7'h10;
    localparam logic [6:0] TX_PULSES_32 = 7'h20;
    localparam logic [6:0] TX_PULSES_64 = 7'h40;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int LATCH_PERIOD_MS = 1000;
    localparam int LATCH_CYCLES    =
        LATCH_PERIOD_MS * 1000000 / CLOCK_PERIOD_NS;

endpackage : line_err_pkg

// ---- rtl/line_error_count_ais_control.sv ----
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// Functional notes
// - Tx absence after 16/32/64 low pulses
// - Two-bit field selects tx absence threshold
// - Bit 7 picks ANSI or FCC zeros
// - Writing bit 6 inserts one violation
// - Violation bit self-clears after insertion
// - Rising bit 5 corrupts one pattern bit
// - Error bit self-clears after insertion
// - Three-bit field selects counted error source
// - Latch mode: manual or every second
// - Manual rising latch bit copies count
// - Bit 3 enables rx alarm, system absence
// - Bit 2 enables rx alarm, line absence
// - Bit 1 enables tx alarm, system absence
// - Bit 0 enables tx alarm, line absence
// - Control and alarm registers reset to zero
// - Per-channel copy at channel address window
// - Line absence after N low pulses
module line_error_count_ais_control #(
    parameter int CHANNEL        = 1,
    parameter int LATCH_CYCLES   = line_err_pkg::LATCH_CYCLES,
    parameter int RX_PULSES_STD0 = 32,
    parameter int RX_PULSES_STD1 = 64
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [10:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // Transmit amplitude monitor
    input  wire logic        tx_pulse_tick,
    input  wire logic [3:0]  tx_below,
    output logic             transmit_signal_absence,
    // Receive amplitude monitor
    input  wire logic        rx_pulse_tick,
    input  wire logic [7:0]  rx_below,
    output logic             line_signal_absence,
    // System side
    input  wire logic        system_signal_absence,
    // Error events
    input  wire logic        line_violation,
    input  wire logic        line_excess_zeros,
    input  wire logic        system_violation,
    input  wire logic        system_excess_zeros,
    input  wire logic        pattern_error,
    // Insertion handshakes
    input  wire logic        tx_mark_slot,
    output logic             violation_strobe,
    input  wire logic        pattern_bit_slot,
    output logic             pattern_error_strobe,
    // Controls to the data paths
    output logic             excess_zeros_standard_select,
    output logic             rx_alarm_signal,
    output logic             tx_alarm_signal,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  absence_cfg;
        logic [7:0]  fault_ctl;
        logic [3:0]  alarm_gen;
        logic [15:0] count;
        logic [7:0]  count_high;
        logic [7:0]  count_low;
        logic [31:0] sec_cnt;
        logic [6:0]  tx_run;
        logic        tx_abs;
        logic [15:0] rx_run;
        logic        line_abs;
        logic [4:0]  int_status;
        logic [4:0]  int_mask;
        logic [7:0]  rdata;
        logic        viol_out;
        logic        err_out;
        logic        rx_ais;
        logic        tx_ais;
        logic        irq;
    } state_t;

    state_t s_q;
    state_t s_d;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [10:0] chan_addr(input logic [5:0] off);
        logic [10:0] base;
        base = (CHANNEL == 0) ? line_err_pkg::CH0_BASE :
               11'((CHANNEL - 1) * 64);
        return base | {5'h00, off};
    endfunction : chan_addr

    function automatic logic [6:0] tx_period(input logic [1:0] sel);
        logic [6:0] n;
        n = line_err_pkg::TX_PULSES_64;
        if (sel == 2'b00)
            n = line_err_pkg::TX_PULSES_16;
        else if (sel == 2'b01)
            n = line_err_pkg::TX_PULSES_32;
        return n;
    endfunction : tx_period

    function automatic logic [15:0] sat_add(input logic [15:0] v,
                                            input logic [1:0]  inc);
        logic [16:0] sum;
        sum = {1'b0, v} + {15'h0000, inc};
        return sum[16] ? 16'hFFFF : sum[15:0];
    endfunction : sat_add

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic              wr_ctl;
    logic [1:0]        inc;
    logic [15:0]       rx_need;
    logic              latch_now;
    logic              tx_below_sel;
    logic              rx_below_sel;
    logic [line_err_pkg::INT_W-1:0] events;
    line_err_pkg::count_src_t src;

    always_comb
    begin
        s_d          = s_q;
        events       = '0;
        wr_ctl       = reg_write &&
                       reg_addr == chan_addr(line_err_pkg::OFF_FAULT_CTL);
        src          = line_err_pkg::count_src_t'(
                       s_q.fault_ctl[line_err_pkg::SRC_LSB +: 3]);
        tx_below_sel = tx_below[
                       s_q.absence_cfg[line_err_pkg::TX_THR_LSB +: 2]];
        rx_below_sel = rx_below[
                       s_q.absence_cfg[line_err_pkg::RX_THR_LSB +: 3]];
        rx_need      = s_q.absence_cfg[line_err_pkg::RX_STD_BIT] ?
                       16'(RX_PULSES_STD1) : 16'(RX_PULSES_STD0);

        // Transmit absence: consecutive intervals under the chosen level.
        if (tx_pulse_tick)
        begin
            if (tx_below_sel)
            begin
                if (s_q.tx_run != 7'h7F)
                    s_d.tx_run = s_q.tx_run + 7'h01;
                if (s_q.tx_run + 7'h01 >= tx_period(
                    s_q.absence_cfg[line_err_pkg::TX_PER_LSB +: 2]))
                    s_d.tx_abs = 1'b1;
            end
            else
            begin
                s_d.tx_run = 7'h00;
                s_d.tx_abs = 1'b0;
            end
        end
        events[line_err_pkg::INT_TX_ABS] = s_d.tx_abs & ~s_q.tx_abs;

        // Line absence uses the receive threshold and interval count.
        if (rx_pulse_tick)
        begin
            if (rx_below_sel)
            begin
                if (s_q.rx_run != 16'hFFFF)
                    s_d.rx_run = s_q.rx_run + 16'h0001;
                if (s_q.rx_run + 16'h0001 >= rx_need)
                    s_d.line_abs = 1'b1;
            end
            else
            begin
                s_d.rx_run   = 16'h0000;
                s_d.line_abs = 1'b0;
            end
        end
        events[line_err_pkg::INT_LINE_ABS] = s_d.line_abs & ~s_q.line_abs;

        // Error source selection; a combined source counts both events.
        case (src)
            line_err_pkg::SRC_OFF:     inc = 2'd0;
            line_err_pkg::SRC_LV:      inc = {1'b0, line_violation};
            line_err_pkg::SRC_LZ:      inc = {1'b0, line_excess_zeros};
            line_err_pkg::SRC_LV_LZ:   inc = {1'b0, line_violation} +
                                             {1'b0, line_excess_zeros};
            line_err_pkg::SRC_SV:      inc = {1'b0, system_violation};
            line_err_pkg::SRC_SZ:      inc = {1'b0, system_excess_zeros};
            line_err_pkg::SRC_SV_SZ:   inc = {1'b0, system_violation} +
                                             {1'b0, system_excess_zeros};
            line_err_pkg::SRC_PATTERN: inc = {1'b0, pattern_error};
            default:                   inc = 2'd0;
        endcase

        // One-second timer runs only in automatic mode.
        latch_now = 1'b0;
        if (s_q.fault_ctl[line_err_pkg::LATCH_MD_BIT])
        begin
            if (s_q.sec_cnt >= 32'(LATCH_CYCLES - 1))
            begin
                s_d.sec_cnt = 32'h0000_0000;
                latch_now   = 1'b1;
            end
            else
                s_d.sec_cnt = s_q.sec_cnt + 32'h0000_0001;
        end
        else
        begin
            s_d.sec_cnt = 32'h0000_0000;
            if (wr_ctl && reg_wdata[line_err_pkg::LATCH_REQ_BIT] &&
                !s_q.fault_ctl[line_err_pkg::LATCH_REQ_BIT])
                latch_now = 1'b1;
        end

        // An event in the transfer cycle opens the next count, not lost.
        if (latch_now)
        begin
            s_d.count_high = s_q.count[15:8];
            s_d.count_low  = s_q.count[7:0];
            s_d.count      = {14'h0000, inc};
            events[line_err_pkg::INT_LATCHED] = 1'b1;
        end
        else
            s_d.count = sat_add(s_q.count, inc);

        // Control register writes; insertion bits only arm on a one.
        if (wr_ctl)
        begin
            s_d.fault_ctl[7] = reg_wdata[line_err_pkg::EXZ_STD_BIT];
            s_d.fault_ctl[4:0] = reg_wdata[4:0];
        end

        // Violation insertion; a fresh write wins over the clear.
        if (s_q.fault_ctl[line_err_pkg::VIOL_INS_BIT] && tx_mark_slot)
        begin
            s_d.fault_ctl[line_err_pkg::VIOL_INS_BIT] = 1'b0;
            events[line_err_pkg::INT_VIOL_DONE] = 1'b1;
        end
        s_d.viol_out = s_q.fault_ctl[line_err_pkg::VIOL_INS_BIT] &
                       tx_mark_slot;
        if (wr_ctl && reg_wdata[line_err_pkg::VIOL_INS_BIT])
            s_d.fault_ctl[line_err_pkg::VIOL_INS_BIT] = 1'b1;

        // Single pattern error on a rising write of the bit.
        if (s_q.fault_ctl[line_err_pkg::SINGLE_ERROR_INSERT_BIT] && pattern_bit_slot)
        begin
            s_d.fault_ctl[line_err_pkg::SINGLE_ERROR_INSERT_BIT] = 1'b0;
            events[line_err_pkg::INT_ERR_DONE] = 1'b1;
        end
        s_d.err_out = s_q.fault_ctl[line_err_pkg::SINGLE_ERROR_INSERT_BIT] &
                      pattern_bit_slot;
        if (wr_ctl && reg_wdata[line_err_pkg::SINGLE_ERROR_INSERT_BIT] &&
            !s_q.fault_ctl[line_err_pkg::SINGLE_ERROR_INSERT_BIT])
            s_d.fault_ctl[line_err_pkg::SINGLE_ERROR_INSERT_BIT] = 1'b1;

        // Other register writes.
        if (reg_write)
        begin
            if (reg_addr == chan_addr(line_err_pkg::OFF_ABSENCE_CFG))
                s_d.absence_cfg = reg_wdata;
            if (reg_addr == chan_addr(line_err_pkg::OFF_ALARM_GEN))
                s_d.alarm_gen = reg_wdata[3:0];
            if (reg_addr == chan_addr(line_err_pkg::OFF_INT_MASK))
                s_d.int_mask = reg_wdata[line_err_pkg::INT_W-1:0];
            if (reg_addr == chan_addr(line_err_pkg::OFF_INT_STATUS))
                s_d.int_status = s_q.int_status &
                                 ~reg_wdata[line_err_pkg::INT_W-1:0];
        end
        // Set wins over a write-one-to-clear in the same cycle.
        s_d.int_status = s_d.int_status | events;
        s_d.irq        = |(s_q.int_status & s_q.int_mask);

        // Alarm indication towards each path.
        s_d.rx_ais =
            (s_q.alarm_gen[line_err_pkg::RX_SYS_BIT] &
             system_signal_absence) |
            (s_q.alarm_gen[line_err_pkg::RX_LINE_BIT] & s_q.line_abs);
        s_d.tx_ais =
            (s_q.alarm_gen[line_err_pkg::TX_SYS_BIT] &
             system_signal_absence) |
            (s_q.alarm_gen[line_err_pkg::TX_LINE_BIT] & s_q.line_abs);

        // Read data stand only in the cycle after the strobe.
        s_d.rdata = 8'h00;
        if (reg_read)
        begin
            if (reg_addr == chan_addr(line_err_pkg::OFF_ABSENCE_CFG))
                s_d.rdata = s_q.absence_cfg;
            else if (reg_addr == chan_addr(line_err_pkg::OFF_FAULT_CTL))
                s_d.rdata = s_q.fault_ctl;
            else if (reg_addr == chan_addr(line_err_pkg::OFF_ALARM_GEN))
                s_d.rdata = {4'h0, s_q.alarm_gen};
            else if (reg_addr == chan_addr(line_err_pkg::OFF_COUNT_HIGH))
                s_d.rdata = s_q.count_high;
            else if (reg_addr == chan_addr(line_err_pkg::OFF_COUNT_LOW))
                s_d.rdata = s_q.count_low;
            else if (reg_addr == chan_addr(line_err_pkg::OFF_INT_STATUS))
                s_d.rdata = {3'h0, s_q.int_status};
            else if (reg_addr == chan_addr(line_err_pkg::OFF_INT_MASK))
                s_d.rdata = {3'h0, s_q.int_mask};
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_q             <= '0;
            s_q.absence_cfg <= line_err_pkg::ABSENCE_CFG_RST;
            s_q.fault_ctl   <= line_err_pkg::FAULT_CTL_RST;
            s_q.alarm_gen   <= line_err_pkg::ALARM_GEN_RST;
        end
        else
            s_q <= s_d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata                    = s_q.rdata;
    assign transmit_signal_absence      = s_q.tx_abs;
    assign line_signal_absence          = s_q.line_abs;
    assign violation_strobe             = s_q.viol_out;
    assign pattern_error_strobe         = s_q.err_out;
    assign excess_zeros_standard_select =
        s_q.fault_ctl[line_err_pkg::EXZ_STD_BIT];
    assign rx_alarm_signal              = s_q.rx_ais;
    assign tx_alarm_signal              = s_q.tx_ais;
    assign irq                          = s_q.irq;

endmodule : line_error_count_ais_control

// ---- tb/line_path_model.sv ----
`timescale 1ns/1ps

module line_path_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Pace
    input  wire logic slow,
    // Insertion slots
    output logic      tx_mark_slot,
    output logic      pattern_bit_slot
);
    // Marks only exist where the line carries ones, so slots are sparse.
    // The slow pace keeps an insertion pending for many cycles.
    logic [3:0] gap_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            gap_q <= 4'h0;
        else
            gap_q <= gap_q + 4'h1;
    end

    assign tx_mark_slot     = slow ? (gap_q == 4'hB) : gap_q[0];
    assign pattern_bit_slot = slow ? (gap_q == 4'h6) : 1'b1;
endmodule : line_path_model

// ---- tb/err_ais_chk.sv ----
`timescale 1ns/1ps

module err_ais_chk (
    // Bus
    input wire logic        clock, rst_n, reg_write, reg_read,
    input wire logic [10:0] reg_addr,
    input wire logic [7:0]  reg_wdata, reg_rdata,
    // Data path
    input wire logic        tx_mark_slot, violation_strobe,
    input wire logic        pattern_bit_slot, pattern_error_strobe,
    input wire logic        system_signal_absence, line_signal_absence,
    input wire logic        rx_alarm_signal, tx_alarm_signal,
    input wire logic        excess_zeros_standard_select
);
    logic [3:0] alm_q;
    logic       zs_q;
    logic       vp_q;
    logic       ep_q;
    wire        wf = reg_write && reg_addr == 11'h00E;

    // Shadow of the control bits; a violation re-arm in the consuming cycle wins, for the error bit the clear wins.
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            alm_q <= 4'h0;
            zs_q  <= 1'b0;
            vp_q  <= 1'b0;
            ep_q  <= 1'b0;
        end
        else
        begin
            if (reg_write && reg_addr == 11'h00F)
                alm_q <= reg_wdata[3:0];
            if (wf)
                zs_q <= reg_wdata[7];
            if (wf && reg_wdata[6])
                vp_q <= 1'b1;
            else if (tx_mark_slot)
                vp_q <= 1'b0;
            if (ep_q && pattern_bit_slot)
                ep_q <= 1'b0;
            else if (wf && reg_wdata[5])
                ep_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_RX_ALARM: assert property (
        rx_alarm_signal == $past(alm_q[3] && system_signal_absence
            || alm_q[2] && line_signal_absence))
        else $error("rx alarm mismatch");
    AST_TX_ALARM: assert property (
        tx_alarm_signal == $past(alm_q[1] && system_signal_absence
            || alm_q[0] && line_signal_absence))
        else $error("tx alarm mismatch");
    AST_ZEROS_SEL: assert property (
        excess_zeros_standard_select == zs_q)
        else $error("zeros standard select mismatch");
    AST_VIOL_STROBE: assert property (
        violation_strobe == $past(vp_q && tx_mark_slot))
        else $error("violation strobe mismatch");
    AST_ERR_STROBE: assert property (
        pattern_error_strobe == $past(ep_q && pattern_bit_slot))
        else $error("pattern error strobe mismatch");
    AST_CTL_READBACK: assert property (
        $past(reg_read && reg_addr == 11'h00E)
        |-> reg_rdata[7:5] == $past({zs_q, vp_q, ep_q}))
        else $error("control readback mismatch");
    AST_ALARM_READBACK: assert property (
        $past(reg_read && reg_addr == 11'h00F)
        |-> reg_rdata == $past({4'h0, alm_q}))
        else $error("alarm readback mismatch");
    AST_OTHER_CH: assert property (
        $past(reg_read && reg_addr == 11'h04E) |-> reg_rdata == 8'h00)
        else $error("foreign channel answered");

    cover property (violation_strobe);
    cover property (pattern_error_strobe);
    cover property (rx_alarm_signal && tx_alarm_signal);
endmodule : err_ais_chk

bind line_error_count_ais_control err_ais_chk i_chk (.clock, .rst_n,
    .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
    .tx_mark_slot, .violation_strobe, .pattern_bit_slot,
    .pattern_error_strobe, .system_signal_absence, .line_signal_absence,
    .rx_alarm_signal, .tx_alarm_signal, .excess_zeros_standard_select);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    logic        clock, rst_n, reg_write, reg_read, rd_d, slow, irq;
    logic [10:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rx_below, exp_list[$];
    logic [3:0]  tx_below;
    logic [4:0]  ev;
    logic        tx_pulse_tick, rx_pulse_tick, system_signal_absence;
    logic        tx_mark_slot, pattern_bit_slot, violation_strobe;
    logic        pattern_error_strobe, transmit_signal_absence;
    logic        line_signal_absence, excess_zeros_standard_select;
    logic        rx_alarm_signal, tx_alarm_signal;
    logic [31:0] rs;
    int          n_fail, checks, nv, ne;

    line_error_count_ais_control #(.LATCH_CYCLES(20), .RX_PULSES_STD0(4))
        i_dut (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .tx_pulse_tick, .tx_below,
        .transmit_signal_absence, .rx_pulse_tick, .rx_below,
        .line_signal_absence, .system_signal_absence,
        .line_violation(ev[0]), .line_excess_zeros(ev[1]),
        .system_violation(ev[2]), .system_excess_zeros(ev[3]),
        .pattern_error(ev[4]), .tx_mark_slot, .violation_strobe,
        .pattern_bit_slot, .pattern_error_strobe,
        .excess_zeros_standard_select, .rx_alarm_signal,
        .tx_alarm_signal, .irq);
    line_path_model i_far (.clock, .rst_n, .slow, .tx_mark_slot,
        .pattern_bit_slot);

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Strobes drop for one cycle between accesses so no signal is
    // assigned twice in one time step.
    task automatic wr(logic [10:0] a, logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(logic [10:0] a, logic [7:0] e);
        exp_list.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask : rd

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    task automatic ticks(int n, logic [3:0] b);
        repeat (n)
        begin
            tx_pulse_tick <= 1'b1;
            tx_below      <= b;
            @(posedge clock);
        end
        tx_pulse_tick <= 1'b0;
        @(posedge clock);
    endtask : ticks

    task automatic count_src(logic [2:0] s);
        logic [63:0] m;
        logic [4:0]  e;
        int          n;
        m = 64'h100C080403020100;
        n = 0;
        wr(11'h00E, {3'h0, s, 2'b01});
        wr(11'h00E, {3'h0, s, 2'b00});
        repeat (12)
        begin
            e = 5'(rnd());
            ev <= e;
            n += $countones(e & m[s * 8 +: 5]);
            @(posedge clock);
        end
        ev <= 5'h00;
        wr(11'h00E, {3'h0, s, 2'b01});
        rd(11'h01A, 8'h00);
        rd(11'h01B, n[7:0]);
    endtask : count_src

    always @(posedge clock)
    begin
        if (rd_d)
            check("rdata", reg_rdata, exp_list.pop_front());
        rd_d <= reg_read && rst_n;
    end

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        finish_test();
    end

    initial
    begin
        {reg_write, reg_read, rd_d, slow, tx_pulse_tick, rx_pulse_tick} = 0;
        {system_signal_absence, rst_n, ev, tx_below, rx_below} = 0;
        reg_addr = 11'h000;
        reg_wdata = 8'h00;
        rs = 32'hF;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(11'h00E, 8'h00);
        rd(11'h00F, 8'h00);
        rd(11'h00D, 8'h15);
        wr(11'h04E, 8'hFF);
        rd(11'h00E, 8'h00);
        rd(11'h04E, 8'h00);
        wr(11'h00E, 8'h80);
        check("zeros_std", excess_zeros_standard_select, 1'b1);
        for (int c = 0; c < 4; c++)
        begin
            wr(11'h00D, {4'h1, c[1:0], c[1:0]});
            nv = (c == 0) ? 16 : (c == 1) ? 32 : 64;
            ticks(nv, ~(4'h1 << c));
            check("tx_abs", transmit_signal_absence, 1'b0);
            ticks(nv - 1, 4'h1 << c);
            check("tx_abs", transmit_signal_absence, 1'b0);
            ticks(1, 4'h1 << c);
            check("tx_abs", transmit_signal_absence, 1'b1);
        end
        // Both interval counts: one clean tick, then N low ticks.
        for (int r = 0; r < 2; r++)
        begin
            wr(11'h00D, {r[0], 7'h15});
            nv = r ? 64 : 4;
            rx_below      <= 8'h00;
            rx_pulse_tick <= 1'b1;
            @(posedge clock);
            rx_below <= 8'h02;
            repeat (nv - 1) @(posedge clock);
            check("line_abs", line_signal_absence, 1'b0);
            @(posedge clock);
            rx_pulse_tick <= 1'b0;
            @(posedge clock);
            check("line_abs", line_signal_absence, 1'b1);
        end
        for (int a = 0; a < 16; a++)
        begin
            system_signal_absence <= 1'(rnd());
            wr(11'h00F, a[7:0]);
            // The alarm is registered one cycle after the new enables.
            @(posedge clock);
            check("rx_alarm", rx_alarm_signal,
                a[3] & system_signal_absence | a[2]);
            check("tx_alarm", tx_alarm_signal,
                a[1] & system_signal_absence | a[0]);
        end
        for (int s = 0; s < 2; s++)
        begin
            slow <= s[0];
            wr(11'h00E, 8'h60);
            nv = 0;
            ne = 0;
            repeat (40)
            begin
                @(posedge clock);
                nv += violation_strobe;
                ne += pattern_error_strobe;
            end
            check("viol_count", nv, 1);
            check("err_count", ne, 1);
            rd(11'h00E, 8'h00);
        end
        for (int s = 0; s < 8; s++)
            count_src(s[2:0]);
        check("irq_masked", irq, 1'b0);
        wr(11'h01D, 8'h04);
        @(posedge clock);
        check("irq", irq, 1'b1);
        wr(11'h01C, 8'h1F);
        wr(11'h00E, 8'h06);
        check("irq_clear", irq, 1'b0);
        nv = 0;
        while (irq !== 1'b1 && nv < 30)
        begin
            @(posedge clock);
            nv++;
        end
        check("auto_latch", irq, 1'b1);
        finish_test();
    end
endmodule : tb_top
